//--- rtl/ttgpu_defs.svh
`ifndef TTGPU_DEFS_SVH
`define TTGPU_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TTGPU_OFS_CTRL_A 8'h00
`define TTGPU_OFS_CTRL_C 8'h04
`define TTGPU_OFS_CTRL_B 8'h08
`define TTGPU_OFS_CNT_A 8'h0c
`define TTGPU_OFS_CNT_C 8'h10
`define TTGPU_OFS_CNT_B 8'h14
`define TTGPU_OFS_STATUS 8'h18
`define TTGPU_OFS_MASK 8'h1c

// ----------------------------------------
// field positions, widths, reset values
// ----------------------------------------
`define TTGPU_CNT_W 16
`define TTGPU_CTRL_W 16
`define TTGPU_EVT_W 5
`define TTGPU_EVT_CAP_A 3
`define TTGPU_EVT_CAP_B 4
`define TTGPU_CTRL_RST 16'h0000
`define TTGPU_CNT_RST 16'h0000
`define TTGPU_MASK_RST 5'h00
`define TTGPU_STATUS_RST 5'h00
`define TTGPU_CNT_MAX 16'hffff
`define TTGPU_CNT_MIN 16'h0000

// ----------------------------------------
// prescaler: factor 8 << select
// ----------------------------------------
`define TTGPU_PRE_W 10
`define TTGPU_PRE_BASE 10'h007
`define TTGPU_PRE_RST 10'h000

// ----------------------------------------
// reload trigger sources
// ----------------------------------------
`define TTGPU_RLD_PIN 2'h0
`define TTGPU_RLD_RISE 2'h1
`define TTGPU_RLD_FALL 2'h2
`define TTGPU_RLD_BOTH 2'h3

`endif

//--- rtl/ttgpu_pkg.sv
package ttgpu_pkg;

	typedef enum logic [1:0] {
		MODE_TIMER,
		MODE_GATED,
		MODE_COUNTER,
		MODE_INCR
	} ttgpu_mode_type;

	typedef enum logic [1:0] {
		AUX_NORMAL,
		AUX_CAPTURE,
		AUX_RELOAD,
		AUX_SPARE
	} ttgpu_aux_type;

	typedef struct packed {
		logic [1:0] reload_src;
		ttgpu_aux_type aux_func;
		logic latch_link;
		logic gate_level;
		logic [1:0] edge_sel;
		logic ext_dir_en;
		logic dir_down;
		logic run;
		logic [2:0] presc;
		ttgpu_mode_type mode;
	} ttgpu_ctrl_type;

	typedef struct packed {
		logic [5:0] level;
		logic [5:0] rise;
		logic [5:0] fall;
	} ttgpu_pins_type;

endpackage

//--- rtl/ttgpu_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ttgpu_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [5:0] pin_in,
	output ttgpu_pkg::ttgpu_pins_type pins
);
	import ttgpu_pkg::*;

	logic [5:0] s1_q;
	logic [5:0] s2_q;
	logic [5:0] s3_q;

	// ----------------------------------------
	// two-stage synchroniser plus history
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= 6'h00;
			s2_q <= 6'h00;
			s3_q <= 6'h00;
		end else if (ce) begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign pins = {s2_q, s2_q & ~s3_q, ~s2_q & s3_q};
endmodule
`default_nettype wire

//--- rtl/ttgpu_top.sv
// Summary of operation
// - each of three timers picks timer, gated, counter or quadrature mode.
// - every timer is a 16-bit counter register.
// - timer mode counts prescaled clock, select 0..7 gives factor 8..1024.
// - counter mode advances on chosen edges of the timer input pin.
// - gated mode counts prescaled ticks only while pin is at gate level.
// - one input pin per timer, used as gate or count clock.
// - direction from software bit, optionally inverted by direction pin.
// - quadrature mode derives count and direction from input and dir pins.
// - core toggle latch inverts on every core overflow and underflow.
// - core toggle latch can be driven onto the toggle output pin.
// - either auxiliary timer can count core toggle latch transitions.
// - auxiliary timer in capture or reload role stops counting.
// - capture copies core count into auxiliary on its input pin edge.
// - reload loads core from auxiliary on pin edge or latch transition.
// - both auxiliaries reloading on opposite transitions give hardware PWM.
// - same prescaler choices serve all timers in timer and gated modes.
//
// Our own choices: the register offsets and the APB slave port.
`include "ttgpu_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ttgpu_top (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [2:0] TIMER_INPUT_PIN,
	input wire logic [2:0] DIRECTION_INPUT_PIN,
	output logic TOGGLE_OUTPUT_PIN,
	output logic IRQ
);
	import ttgpu_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic presc_tick(input logic [9:0] pre,
		input logic [2:0] sel);
		logic [9:0] msk;
		msk = ((`TTGPU_PRE_BASE + 10'h001) << sel) - 10'h001;
		return (pre & msk) == msk;
	endfunction

	function automatic logic edge_hit(input logic [1:0] sel,
		input logic r, input logic f);
		return (sel[0] & r) | (sel[1] & f);
	endfunction

	function automatic logic [15:0] step(input logic [15:0] v,
		input logic down);
		return down ? v - 16'h0001 : v + 16'h0001;
	endfunction

	function automatic logic quad_up(input logic a_edge,
		input logic a, input logic b);
		return a_edge ? a != b : a == b;
	endfunction

	function automatic logic wrap_hit(input logic [15:0] v,
		input logic down);
		return down ? v == `TTGPU_CNT_MIN : v == `TTGPU_CNT_MAX;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	ttgpu_ctrl_type ctrl_q [3];
	logic [15:0] cnt_q [3];
	logic [15:0] cnt_d [3];
	logic [9:0] pre_q;
	logic latch_q;
	logic lat_rise_q;
	logic lat_fall_q;
	logic [4:0] status_q;
	logic [4:0] mask_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;
	logic tog_q;
	ttgpu_pins_type pins;

	logic [2:0] en;
	logic [2:0] dn;
	logic [2:0] ovf;
	logic lat_rise;
	logic lat_fall;
	logic [1:0] cap_hit;
	logic [1:0] rld_hit;

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	ttgpu_sync u_sync (
		.clk(CLOCK),
		.rst(RST),
		.ce(CE),
		.pin_in({DIRECTION_INPUT_PIN, TIMER_INPUT_PIN}),
		.pins(pins)
	);

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire acc_start = PSEL & PENABLE & ~pready_q;
	wire acc_done = PSEL & PENABLE & pready_q;
	wire [7:0] adr = {PADDR[7:2], 2'b00};
	wire sel_ca = adr == `TTGPU_OFS_CTRL_A;
	wire sel_cc = adr == `TTGPU_OFS_CTRL_C;
	wire sel_cb = adr == `TTGPU_OFS_CTRL_B;
	wire sel_na = adr == `TTGPU_OFS_CNT_A;
	wire sel_nc = adr == `TTGPU_OFS_CNT_C;
	wire sel_nb = adr == `TTGPU_OFS_CNT_B;
	wire sel_st = adr == `TTGPU_OFS_STATUS;
	wire sel_mk = adr == `TTGPU_OFS_MASK;
	wire mapped = sel_ca | sel_cc | sel_cb | sel_na | sel_nc | sel_nb |
		sel_st | sel_mk;
	wire wr_done = acc_done & PWRITE & mapped;
	wire rd_st_done = acc_done & ~PWRITE & sel_st;
	wire [2:0] wr_ctrl = {sel_cb, sel_cc, sel_ca} & {3{wr_done}};
	wire [2:0] wr_cnt = {sel_nb, sel_nc, sel_na} & {3{wr_done}};
	wire [31:0] rd_ctrl_a = {16'h0000, ctrl_q[0]};
	wire [31:0] rd_ctrl_c = {16'h0000, ctrl_q[1]};
	wire [31:0] rd_ctrl_b = {16'h0000, ctrl_q[2]};
	wire [31:0] rd_cnt_a = {16'h0000, cnt_q[0]};
	wire [31:0] rd_cnt_c = {16'h0000, cnt_q[1]};
	wire [31:0] rd_cnt_b = {16'h0000, cnt_q[2]};
	wire [31:0] rd_status = {27'h0000000, status_q};
	wire [31:0] rd_mask = {27'h0000000, mask_q};
	wire [31:0] rd_mux =
		sel_ca ? rd_ctrl_a :
		sel_cc ? rd_ctrl_c :
		sel_cb ? rd_ctrl_b :
		sel_na ? rd_cnt_a :
		sel_nc ? rd_cnt_c :
		sel_nb ? rd_cnt_b :
		sel_st ? rd_status :
		sel_mk ? rd_mask : 32'h00000000;

	// ----------------------------------------
	// per-timer count enable and direction
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			logic tick;
			logic phit;
			logic lhit;
			logic qa;
			logic qb;
			logic qup;
			logic sdir;
			tick = presc_tick(pre_q, ctrl_q[i].presc);
			phit = edge_hit(ctrl_q[i].edge_sel, pins.rise[i],
				pins.fall[i]);
			lhit = edge_hit(ctrl_q[i].edge_sel, lat_rise_q, lat_fall_q);
			qa = pins.rise[i] | pins.fall[i];
			qb = pins.rise[i+3] | pins.fall[i+3];
			qup = quad_up(qa, pins.level[i], pins.level[i+3]);
			sdir = ctrl_q[i].dir_down ^
				(ctrl_q[i].ext_dir_en & pins.level[i+3]);
			en[i] = 1'b0;
			dn[i] = sdir;
			unique case (ctrl_q[i].mode)
				MODE_TIMER: begin
					en[i] = tick;
				end
				MODE_GATED: begin
					en[i] = tick &
						(pins.level[i] == ctrl_q[i].gate_level);
				end
				MODE_COUNTER: begin
					if (i != 1 && ctrl_q[i].latch_link) begin
						en[i] = lhit;
					end else begin
						en[i] = phit;
					end
				end
				MODE_INCR: begin
					en[i] = qa | qb;
					dn[i] = ctrl_q[i].dir_down ^ ~qup;
				end
			endcase
			if (!ctrl_q[i].run) begin
				en[i] = 1'b0;
			end
			if (i != 1 && ctrl_q[i].aux_func != AUX_NORMAL) begin
				en[i] = 1'b0;
			end
			ovf[i] = en[i] & wrap_hit(cnt_q[i], dn[i]);
		end
	end

	// ----------------------------------------
	// core toggle latch transitions
	// ----------------------------------------
	assign lat_rise = ovf[1] & ~latch_q;
	assign lat_fall = ovf[1] & latch_q;

	// ----------------------------------------
	// capture and reload triggers
	// ----------------------------------------
	always_comb begin
		for (int j = 0; j < 2; j++) begin
			int k;
			logic phit;
			logic trig;
			k = j * 2;
			trig = 1'b0;
			phit = edge_hit(ctrl_q[k].edge_sel, pins.rise[k], pins.fall[k]);
			unique case (ctrl_q[k].reload_src)
				`TTGPU_RLD_PIN: trig = phit;
				`TTGPU_RLD_RISE: trig = lat_rise;
				`TTGPU_RLD_FALL: trig = lat_fall;
				`TTGPU_RLD_BOTH: trig = ovf[1];
			endcase
			cap_hit[j] = (ctrl_q[k].aux_func == AUX_CAPTURE) & phit;
			rld_hit[j] = (ctrl_q[k].aux_func == AUX_RELOAD) & trig;
		end
	end

	// ----------------------------------------
	// next count values
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			cnt_d[i] = en[i] ? step(cnt_q[i], dn[i]) : cnt_q[i];
		end
		if (rld_hit[0]) begin
			cnt_d[1] = cnt_q[0];
		end else if (rld_hit[1]) begin
			cnt_d[1] = cnt_q[2];
		end
		if (cap_hit[0]) begin
			cnt_d[0] = cnt_q[1];
		end
		if (cap_hit[1]) begin
			cnt_d[2] = cnt_q[1];
		end
		for (int i = 0; i < 3; i++) begin
			if (wr_cnt[i]) begin
				cnt_d[i] = PWDATA[15:0];
			end
		end
	end

	wire [4:0] evt = {cap_hit[1], cap_hit[0], ovf};
	// clear only bits already read out
	wire [4:0] st_clr = rd_st_done ? prdata_q[4:0] : 5'h00;
	wire [4:0] status_d = evt | (status_q & ~st_clr);

	// ----------------------------------------
	// timer counts and controls
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			for (int i = 0; i < 3; i++) begin
				cnt_q[i] <= `TTGPU_CNT_RST;
				ctrl_q[i] <= `TTGPU_CTRL_RST;
			end
		end else if (CE) begin
			for (int i = 0; i < 3; i++) begin
				cnt_q[i] <= cnt_d[i];
				if (wr_ctrl[i]) begin
					ctrl_q[i] <= ttgpu_ctrl_type'(PWDATA[15:0]);
				end
			end
		end
	end

	// ----------------------------------------
	// prescaler and core toggle latch
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			pre_q <= `TTGPU_PRE_RST;
			latch_q <= 1'b0;
			lat_rise_q <= 1'b0;
			lat_fall_q <= 1'b0;
		end else if (CE) begin
			pre_q <= pre_q + 10'h001;
			latch_q <= latch_q ^ ovf[1];
			lat_rise_q <= lat_rise;
			lat_fall_q <= lat_fall;
		end
	end

	// ----------------------------------------
	// status and mask
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			status_q <= `TTGPU_STATUS_RST;
			mask_q <= `TTGPU_MASK_RST;
		end else if (CE) begin
			status_q <= status_d;
			if (wr_done && sel_mk) begin
				mask_q <= PWDATA[4:0];
			end
		end
	end

	// ----------------------------------------
	// interrupt and toggle pin
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			irq_q <= 1'b0;
			tog_q <= 1'b0;
		end else if (CE) begin
			irq_q <= |(status_d & mask_q);
			tog_q <= latch_q & ctrl_q[1].latch_link;
		end
	end

	// ----------------------------------------
	// apb answer, one wait state
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else if (CE) begin
			pready_q <= acc_start;
			pslverr_q <= acc_start & ~mapped;
			if (acc_start && !PWRITE) begin
				prdata_q <= rd_mux;
			end
		end
	end

	assign PRDATA = prdata_q;
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign IRQ = irq_q;
	assign TOGGLE_OUTPUT_PIN = tog_q;
endmodule
`default_nettype wire

//--- verif/ttgpu_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ttgpu_checker (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic TOGGLE_OUTPUT_PIN,
	input wire logic IRQ
);
	// ----
	// apb timing
	// ----
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	wire take = PSEL && PENABLE && !PREADY && CE;
	wire wr_done = PSEL && PREADY && PWRITE && CE;
	ready_one_a: assert property (take |=> PREADY)
		else $error("access not answered after one wait state");
	ready_pulse_a: assert property (PREADY && CE |=> !PREADY)
		else $error("ready held longer than one cycle");
	err_decode_a: assert property (take |=> PSLVERR == (PADDR > 8'h1f))
		else $error("error response does not match address decode");
	err_ready_a: assert property (PSLVERR |-> PREADY)
		else $error("error response without ready");
	rdata_hold_a: assert property (!PREADY |-> $stable(PRDATA))
		else $error("read data moved outside a read answer");
	// ----
	// interrupt and toggle output
	// ----
	irq_masked_a: assert property (
		wr_done && PADDR == 8'h1c && PWDATA[4:0] == 5'h00 |=> ##1 !IRQ)
		else $error("interrupt high with all sources masked");
	toggle_link_a: assert property (
		wr_done && PADDR == 8'h04 && !PWDATA[11] |=> ##1 !TOGGLE_OUTPUT_PIN)
		else $error("toggle pin driven with output link off");
	reset_quiet_a: assert property (
		$fell(RST) |-> !IRQ && !TOGGLE_OUTPUT_PIN && !PREADY && !PSLVERR)
		else $error("outputs not quiet after reset");
	cover property (take && PWRITE);
	cover property (PSLVERR);
	cover property ($rose(TOGGLE_OUTPUT_PIN));
endmodule
bind ttgpu_top ttgpu_checker u_ttgpu_checker (.CLOCK, .RST, .CE, .PSEL,
	.PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
	.TOGGLE_OUTPUT_PIN, .IRQ);
`default_nettype wire

//--- verif/ttgpu_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module ttgpu_pins_model (
	input wire logic clk,
	output logic [2:0] tin,
	output logic [2:0] tdir
);
	// ----
	// external pin levels
	// ----
	initial begin
		tin = 3'h0;
		tdir = 3'h0;
	end
	task automatic tgl(input logic [2:0] a, input logic [2:0] b);
		@(posedge clk);
		tin <= tin ^ a;
		tdir <= tdir ^ b;
		repeat (5) @(posedge clk);
	endtask
endmodule
`default_nettype wire

//--- verif/three_timer_gp_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module three_timer_gp_unit_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, tgl_out, irq;
	logic ce = 1'b1;
	logic [33:0] n;
	logic [33:0] q[$];
	wire [2:0] tin, tdir;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	int t0, lo, hi;

	always #12.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	ttgpu_pins_model u_pins (.clk(clk), .tin(tin), .tdir(tdir));
	ttgpu_top u_ttgpu_top (.CLOCK(clk), .RST(rst), .CE(ce), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.TIMER_INPUT_PIN(tin), .DIRECTION_INPUT_PIN(tdir),
		.TOGGLE_OUTPUT_PIN(tgl_out), .IRQ(irq));

	// ----
	// compare and close
	// ----
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ----
	// apb master, note is {check data, error, data}
	// ----
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [33:0] nt);
		int i;
		q.push_back(nt);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			error_cnt++;
			finish_test;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 34'h0);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {2'b10, e});
	endtask

	always @(posedge clk) begin
		if (pready === 1'b1 && q.size() > 0) begin
			n = q.pop_front();
			check({31'h0, pslverr}, {31'h0, n[32]});
			if (n[33]) check(prdata, n[31:0]);
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		finish_test;
	end

	initial begin
		void'($urandom(32'h716773e8));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(8'h04, 32'h0);
		rd(8'h1c, 32'h0);
		r = $urandom;
		wr(8'h10, r);
		rd(8'h10, {16'h0, r[15:0]});
		apb(1'b1, 8'h24, r, 34'h100000000);
		apb(1'b0, 8'h20, 32'h0, 34'h100000000);
		$display("test done: registers");
		wr(8'h1c, 32'h1f);
		wr(8'h0c, 32'hffff);
		wr(8'h00, 32'h0122);
		repeat (4) u_pins.tgl(3'h1, 3'h0);
		check({31'h0, irq}, 32'h1);
		rd(8'h0c, 32'h1);
		rd(8'h18, 32'h1);
		rd(8'h18, 32'h0);
		$display("test done: count up and wrap");
		wr(8'h14, 32'h0);
		wr(8'h08, 32'h0162);
		repeat (2) u_pins.tgl(3'h4, 3'h0);
		wr(8'h1c, 32'h0);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		rd(8'h14, 32'hffff);
		rd(8'h18, 32'h4);
		wr(8'h1c, 32'h1f);
		$display("test done: count down and mask");
		wr(8'h10, 32'hffff);
		wr(8'h04, 32'h0823);
		u_pins.tgl(3'h2, 3'h0);
		u_pins.tgl(3'h0, 3'h2);
		check({31'h0, tgl_out}, 32'h1);
		rd(8'h10, 32'h1);
		rd(8'h18, 32'h2);
		$display("test done: quadrature and toggle");
		wr(8'h08, 32'h1100);
		repeat (2) u_pins.tgl(3'h4, 3'h0);
		rd(8'h14, 32'h1);
		rd(8'h18, 32'h10);
		wr(8'h04, 32'h0);
		repeat (2) @(posedge clk);
		check({31'h0, tgl_out}, 32'h0);
		$display("test done: capture");
		wr(8'h0c, 32'hfffe);
		wr(8'h14, 32'hfffd);
		wr(8'h00, 32'h6000);
		wr(8'h08, 32'ha000);
		wr(8'h10, 32'hffff);
		wr(8'h04, 32'h0b22);
		repeat (4) u_pins.tgl(3'h2, 3'h0);
		check({31'h0, tgl_out}, 32'h1);
		rd(8'h10, 32'hfffe);
		repeat (2) u_pins.tgl(3'h2, 3'h0);
		check({31'h0, tgl_out}, 32'h0);
		rd(8'h10, 32'hfffd);
		rd(8'h0c, 32'hfffe);
		wr(8'h04, 32'h0);
		$display("test done: reload waveform");
		wr(8'h0c, 32'h0);
		wr(8'h00, 32'h0421);
		repeat (40) @(posedge clk);
		rd(8'h0c, 32'h0);
		wr(8'h00, 32'h0024);
		t0 = cyc;
		repeat (20) @(posedge clk);
		ce <= 1'b0;
		repeat (40) @(posedge clk);
		ce <= 1'b1;
		repeat (20) @(posedge clk);
		wr(8'h00, 32'h0004);
		t0 = cyc - t0 - 40;
		apb(1'b0, 8'h0c, 32'h0, 34'h0);
		lo = t0 / 16;
		hi = (t0 + 15) / 16;
		check({31'h0, (prdata >= lo && prdata <= hi)}, 32'h1);
		$display("test done: timer, gate and clock enable");
		@(posedge clk);
		finish_test;
	end
endmodule
`default_nettype wire
